// file: aotc_regs.svh
`ifndef AOTC_REGS_SVH
`define AOTC_REGS_SVH
// ==========================================
// Register offsets
`define AOTC_ADDR_ENH 8'h0c
`define AOTC_ADDR_TEST 8'h0d
`define AOTC_ADDR_OFFS 8'h10
`define AOTC_ADDR_OFMT 8'h14
`define AOTC_ADDR_ODRV 8'h15
`define AOTC_ADDR_OPHS 8'h16
`define AOTC_ADDR_VREF 8'h18
// ==========================================
// Reset values
`define AOTC_RST_ENH 8'h00
`define AOTC_RST_TEST 8'h00
`define AOTC_RST_OFFS 8'h00
`define AOTC_RST_OFMT 8'h01
`define AOTC_RST_ODRV 8'h00
`define AOTC_RST_OPHS 8'h03
`define AOTC_RST_VREF 8'h04
// ==========================================
// Field positions and writable masks
`define AOTC_TEST_MODE_LSB 0
`define AOTC_TEST_RST_SHORT_BIT 4
`define AOTC_TEST_RST_LONG_BIT 5
`define AOTC_TEST_SEQ_LSB 6
`define AOTC_OFMT_TWOS_BIT 0
`define AOTC_OFMT_INV_BIT 2
`define AOTC_ENH_CHOP_BIT 2
`define AOTC_OPHS_OUT_LSB 0
`define AOTC_OPHS_IN_LSB 4
`define AOTC_OPHS_OUT_MAX 4'hb
`define AOTC_MASK_ENH 8'h04
`define AOTC_MASK_OFMT 8'h45
`define AOTC_MASK_ODRV 8'h31
`define AOTC_MASK_OPHS 8'h7f
`define AOTC_MASK_VREF 8'h07
// ==========================================
// Fixed pattern words (16-bit, left-justified sample)
`define AOTC_PAT_MID 16'h8000
`define AOTC_PAT_PFS 16'hfff0
`define AOTC_PAT_NFS 16'h0000
`define AOTC_PAT_CHK 16'haaa0
`define AOTC_PAT_SYNC 16'hfc00
`define AOTC_PAT_ONEBIT 16'h8000
`define AOTC_PAT_MIX 16'ha330
`endif

// file: aotc_pkg.sv
`default_nettype none
package aotc_pkg;
  typedef enum logic [3:0] {
    AOTC_TM_OFF, AOTC_TM_MID, AOTC_TM_PFS, AOTC_TM_NFS, AOTC_TM_CHECKER,
    AOTC_TM_PN23, AOTC_TM_PN9, AOTC_TM_WORDTOG, AOTC_TM_USER,
    AOTC_TM_BITTOG, AOTC_TM_SYNC, AOTC_TM_ONEBIT, AOTC_TM_MIXED
  } aotc_mode_e;
  typedef enum logic [1:0] {
    AOTC_SEQ_REPEAT, AOTC_SEQ_ALT, AOTC_SEQ_ONCE, AOTC_SEQ_ALT_ONCE
  } aotc_seq_e;
  typedef logic [7:0] aotc_byte_t;
endpackage
`default_nettype wire

// file: aotc_prbs.sv
`timescale 1ns/1ns
`default_nettype none
// Free-running pseudorandom generator; width chooses the sequence length
module aotc_prbs #(
  parameter int STAGES = 23,
  parameter int TAP = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic restart,
  output logic [15:0] word
);
  logic [STAGES-1:0] lfsr_ff;
  // Refuse lengths whose top sixteen stages cannot form the output word
  if (STAGES < 16 || TAP >= STAGES || TAP < 1) begin : g_bad_taps
    $error("aotc_prbs: bad taps");
  end
  // ==========================================
  // Shift register, restart to all ones start state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_ff <= '1;
    end else if (ce) begin
      if (restart) begin
        lfsr_ff <= '1; // R03
      end else begin
        lfsr_ff <= {lfsr_ff[STAGES-2:0], lfsr_ff[STAGES-1] ^ lfsr_ff[TAP-1]};
      end
    end
  end
  assign word = lfsr_ff[STAGES-1 -: 16];
endmodule
`default_nettype wire

// file: aotc_top.sv
// What this block does
// R01: Zero test mode passes conversion samples
// R02: Codes one to four give fixed patterns
// R03: Codes five, six give PRBS; resettable
// R04: Codes seven to twelve give further patterns
// R05: Sequencing field steers user pattern playback
// R06: Output clock phase selects divider phase
// R07: Input phase delays by programmed cycles
// R08: Format bit picks twos complement; invert
`include "aotc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module aotc_top
  import aotc_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int PHASES = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [SAMPLE_W-1:0] adc_sample,
  input wire logic [15:0] user_pattern1,
  input wire logic [15:0] user_pattern2,
  input wire logic [PHASES-1:0] divider_phases,
  output logic out_clock,
  output logic [SAMPLE_W-1:0] out_data,
  output logic chop_enable,
  output logic [1:0] drive_termination,
  output logic drive_double,
  output logic lvds_reduced,
  output logic [2:0] vref_select,
  output logic [7:0] offset_trim_value
);
  // The format flip needs a sign bit and at least one bit below it
  if (SAMPLE_W < 2 || SAMPLE_W > 16) begin : g_bad_width
    $error("aotc_top: SAMPLE_W out of range");
  end
  if (PHASES < 12) begin : g_bad_phases
    $error("aotc_top: need 12 divider phases");
  end

  // ==========================================
  // Reset release through two flops
  logic rst_a_ff, rst_b_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  wire rst_n = rst_b_ff;

  // ==========================================
  // Register file
  aotc_byte_t enh_ff, test_ff, offs_ff, ofmt_ff, odrv_ff, ophs_ff, vref_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enh_ff <= `AOTC_RST_ENH;
      test_ff <= `AOTC_RST_TEST;
      offs_ff <= `AOTC_RST_OFFS;
      ofmt_ff <= `AOTC_RST_OFMT;
      odrv_ff <= `AOTC_RST_ODRV;
      ophs_ff <= `AOTC_RST_OPHS;
      vref_ff <= `AOTC_RST_VREF;
    end else if (ce && reg_wr) begin
      if (reg_addr == `AOTC_ADDR_ENH) begin
        enh_ff <= reg_wdata & `AOTC_MASK_ENH;
      end else if (reg_addr == `AOTC_ADDR_TEST) begin
        test_ff <= reg_wdata;
      end else if (reg_addr == `AOTC_ADDR_OFFS) begin
        offs_ff <= reg_wdata;
      end else if (reg_addr == `AOTC_ADDR_OFMT) begin
        ofmt_ff <= reg_wdata & `AOTC_MASK_OFMT;
      end else if (reg_addr == `AOTC_ADDR_ODRV) begin
        odrv_ff <= reg_wdata & `AOTC_MASK_ODRV;
      end else if (reg_addr == `AOTC_ADDR_OPHS) begin
        ophs_ff <= reg_wdata & `AOTC_MASK_OPHS;
      end else if (reg_addr == `AOTC_ADDR_VREF) begin
        vref_ff <= reg_wdata & `AOTC_MASK_VREF;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    if (reg_addr == `AOTC_ADDR_ENH) begin
      reg_rdata = enh_ff;
    end else if (reg_addr == `AOTC_ADDR_TEST) begin
      reg_rdata = test_ff;
    end else if (reg_addr == `AOTC_ADDR_OFFS) begin
      reg_rdata = offs_ff;
    end else if (reg_addr == `AOTC_ADDR_OFMT) begin
      reg_rdata = ofmt_ff;
    end else if (reg_addr == `AOTC_ADDR_ODRV) begin
      reg_rdata = odrv_ff;
    end else if (reg_addr == `AOTC_ADDR_OPHS) begin
      reg_rdata = ophs_ff;
    end else if (reg_addr == `AOTC_ADDR_VREF) begin
      reg_rdata = vref_ff;
    end else begin
      reg_rdata = 8'h00;
    end
  end

  // Static configuration straight from the registers
  assign chop_enable = enh_ff[`AOTC_ENH_CHOP_BIT];
  assign drive_termination = odrv_ff[5:4];
  assign drive_double = odrv_ff[0];
  assign lvds_reduced = ofmt_ff[6];
  assign vref_select = vref_ff[2:0];
  assign offset_trim_value = offs_ff;

  wire [3:0] mode = test_ff[3:0];
  wire [1:0] seq = test_ff[7:6];
  wire twos = ofmt_ff[`AOTC_OFMT_TWOS_BIT];
  wire invert = ofmt_ff[`AOTC_OFMT_INV_BIT];
  wire [3:0] out_phase = ophs_ff[3:0];
  wire [2:0] in_phase = ophs_ff[6:4];

  // ==========================================
  // Pseudorandom generators; reset bits hold them at start state
  logic [15:0] pn_long, pn_short;
  aotc_prbs #(.STAGES(23), .TAP(18)) u_pn_long (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .restart(test_ff[`AOTC_TEST_RST_LONG_BIT]), .word(pn_long) // R03
  );
  aotc_prbs #(.STAGES(19), .TAP(14)) u_pn_short (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .restart(test_ff[`AOTC_TEST_RST_SHORT_BIT]), .word(pn_short) // R03
  );

  // ==========================================
  // Toggle phase and user pattern sequencer
  logic tog_ff, user_sel_ff, user_done_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_ff <= 1'b0;
      user_sel_ff <= 1'b0;
      user_done_ff <= 1'b0;
    end else if (ce) begin
      tog_ff <= ~tog_ff;
      if (mode != 4'(AOTC_TM_USER)) begin
        user_sel_ff <= 1'b0; // Restart playback on re-entry
        user_done_ff <= 1'b0;
      end else if (!user_done_ff) begin
        case (aotc_seq_e'(seq)) // R05
          AOTC_SEQ_REPEAT: user_sel_ff <= 1'b0;
          AOTC_SEQ_ALT: user_sel_ff <= ~user_sel_ff;
          AOTC_SEQ_ONCE: user_done_ff <= 1'b1;
          AOTC_SEQ_ALT_ONCE: begin
            user_sel_ff <= ~user_sel_ff;
            if (user_sel_ff) user_done_ff <= 1'b1;
          end
          default: user_sel_ff <= 1'b0;
        endcase
      end
    end
  end

  // User word; after a single-shot run the line idles at zero
  function automatic logic [15:0] user_word(input logic done, input logic sel,
                                            input logic [15:0] p1, input logic [15:0] p2);
    if (done) return 16'h0000;
    return sel ? p2 : p1;
  endfunction

  // ==========================================
  // Pattern select; normal data when mode is zero
  logic [15:0] pat;
  logic use_sample;
  always_comb begin
    use_sample = 1'b0;
    pat = 16'h0000;
    case (aotc_mode_e'(mode))
      AOTC_TM_OFF: use_sample = 1'b1; // R01
      AOTC_TM_MID: pat = `AOTC_PAT_MID; // R02
      AOTC_TM_PFS: pat = `AOTC_PAT_PFS; // R02
      AOTC_TM_NFS: pat = `AOTC_PAT_NFS; // R02
      AOTC_TM_CHECKER: pat = tog_ff ? ~`AOTC_PAT_CHK : `AOTC_PAT_CHK; // R02
      AOTC_TM_PN23: pat = pn_long; // R03
      AOTC_TM_PN9: pat = pn_short; // R03
      AOTC_TM_WORDTOG: pat = tog_ff ? 16'hffff : 16'h0000; // R04
      AOTC_TM_USER: pat = user_word(user_done_ff, user_sel_ff, user_pattern1, user_pattern2); // R04
      AOTC_TM_BITTOG: pat = tog_ff ? 16'h5555 : 16'haaaa; // R04
      AOTC_TM_SYNC: pat = `AOTC_PAT_SYNC; // R04
      AOTC_TM_ONEBIT: pat = `AOTC_PAT_ONEBIT; // R04
      AOTC_TM_MIXED: pat = `AOTC_PAT_MIX; // R04
      default: use_sample = 1'b1; // Reserved codes fall back to samples
    endcase
  end

  // ==========================================
  // Input phase delay line, up to seven cycles
  logic [SAMPLE_W-1:0] dly_ff [8];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) dly_ff[i] <= '0;
    end else if (ce) begin
      dly_ff[0] <= adc_sample;
      for (int i = 1; i < 8; i++) dly_ff[i] <= dly_ff[i-1];
    end
  end
  // Value zero takes the undelayed sample
  wire [SAMPLE_W-1:0] delayed = (in_phase == 3'd0) ? adc_sample : dly_ff[in_phase - 3'd1]; // R07

  // ==========================================
  // Output word: format, invert, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
    end else if (ce) begin
      if (use_sample) begin
        out_data <= (delayed ^ {twos, {(SAMPLE_W-1){1'b0}}}) ^ {SAMPLE_W{invert}}; // R08
      end else begin
        out_data <= pat[15 -: SAMPLE_W] ^ {SAMPLE_W{invert}}; // R08
      end
    end
  end

  // ==========================================
  // Output clock phase pick; codes above 11 clamp so the clock keeps running outside reset
  wire [3:0] ph_idx = (out_phase > `AOTC_OPHS_OUT_MAX) ? `AOTC_OPHS_OUT_MAX : out_phase;
  assign out_clock = rst_n & divider_phases[ph_idx]; // R06

  // ==========================================
  // Checks
  a_mode_zero_pass: assert property (@(posedge clk) disable iff (!rst_n) // R01
    ce && mode == 4'h0 && !invert && !twos && in_phase == 3'd0 |=> out_data == $past(adc_sample))
    else $error("sample not passed in normal mode");
  a_pfs_pattern: assert property (@(posedge clk) disable iff (!rst_n) // R02
    ce && mode == 4'h2 && !invert |=> out_data == {SAMPLE_W{1'b1}})
    else $error("positive full scale wrong");
  a_prbs_hold: assert property (@(posedge clk) disable iff (!rst_n) // R03
    ce && test_ff[`AOTC_TEST_RST_LONG_BIT] ##1 ce |-> pn_long == 16'hffff)
    else $error("long generator not held at start");
  // Invert must stay off on both edges, a change of it between them would cancel the toggle
  a_word_toggle: assert property (@(posedge clk) disable iff (!rst_n) // R04
    ce && mode == 4'h7 && !invert ##1 ce && mode == 4'h7 && !invert |=> out_data != $past(out_data))
    else $error("word toggle stuck");
  sequence s_user_two;
    ce && mode == 4'h8 && seq == 2'b11 ##1 ce && mode == 4'h8 && seq == 2'b11;
  endsequence
  a_user_alt_once: assert property (@(posedge clk) disable iff (!rst_n) // R05
    !user_done_ff && !user_sel_ff ##0 s_user_two |=> user_done_ff)
    else $error("alternate-once did not finish");
  a_out_phase: assert property (@(posedge clk) disable iff (!rst_n) // R06
    out_phase <= 4'hb |-> out_clock == divider_phases[out_phase])
    else $error("wrong output clock phase");
  // The delay line only moves while enabled, so the three edges before must all have been enabled
  a_in_delay: assert property (@(posedge clk) disable iff (!rst_n) // R07
    ce && $past(ce) && $past(ce, 2) && $past(ce, 3) && mode == 4'h0 && in_phase == 3'd3
    && !invert && !twos |=> out_data == $past(adc_sample, 4))
    else $error("input phase delay wrong");
  a_invert: assert property (@(posedge clk) disable iff (!rst_n) // R08
    ce && mode == 4'h3 && invert |=> out_data == {SAMPLE_W{1'b1}})
    else $error("invert not applied");
endmodule
`default_nettype wire

// file: aotc_cap_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Capture side of the sample stream
module aotc_cap_model #(
  parameter int SAMPLE_W = 12
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic [SAMPLE_W-1:0] out_data,
  output logic [SAMPLE_W-1:0] prev_word
);
  logic [SAMPLE_W-1:0] prev_ff;
  // Holds the word taken at the last enabled edge, so the bench can see pairs
  always_ff @(posedge clk) begin
    if (ce) begin
      prev_ff <= out_data;
    end
  end
  assign prev_word = prev_ff;
endmodule
`default_nettype wire

// file: tb_top.sv
`include "aotc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import aotc_pkg::*;
;
  logic clk = 0;
  logic resetn = 0;
  logic ce = 1;
  logic reg_wr = 0;
  aotc_byte_t reg_addr = 8'h00;
  aotc_byte_t reg_wdata = 8'h00;
  aotc_byte_t reg_rdata;
  logic [11:0] adc_sample = 12'h5a3;
  logic [15:0] up1 = 16'h1234;
  logic [15:0] up2 = 16'hfedc;
  logic [11:0] div_ph = 12'h0a5;
  logic out_clock, chop_enable, drive_double, lvds_reduced;
  logic [11:0] out_data, prev;
  logic [1:0] drive_termination;
  logic [2:0] vref_select;
  logic [7:0] offset_trim_value;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n0, n1;
  aotc_byte_t adr [7] = '{`AOTC_ADDR_ENH, `AOTC_ADDR_TEST, `AOTC_ADDR_OFFS, `AOTC_ADDR_OFMT,
                          `AOTC_ADDR_ODRV, `AOTC_ADDR_OPHS, `AOTC_ADDR_VREF};
  aotc_byte_t rst [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h04};
  aotc_byte_t msk [7] = '{8'h04, 8'hff, 8'hff, 8'h45, 8'h31, 8'h7f, 8'h07};
  logic [3:0] fmode [6] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hc};
  logic [11:0] fpat [6] = '{12'h800, 12'hfff, 12'h000, 12'hfc0, 12'h800, 12'ha33};
  logic [3:0] amode [3] = '{4'h4, 4'h7, 4'h9};

  always #5 clk = ~clk;

  aotc_top u_aotc_top (.clk(clk), .resetn(resetn), .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_sample(adc_sample), .user_pattern1(up1),
    .user_pattern2(up2), .divider_phases(div_ph), .out_clock(out_clock), .out_data(out_data),
    .chop_enable(chop_enable), .drive_termination(drive_termination), .drive_double(drive_double),
    .lvds_reduced(lvds_reduced), .vref_select(vref_select), .offset_trim_value(offset_trim_value));
  aotc_cap_model u_aotc_cap_model (.clk(clk), .ce(ce), .out_data(out_data), .prev_word(prev));

  // ==========================================
  // Access and compare tasks
  task automatic wr(input aotc_byte_t a, input aotc_byte_t d);
    @(posedge clk) #1;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 0;
    // Output word follows one edge after the register, so let both land
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic chk_reg(input aotc_byte_t g, input aotc_byte_t e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input aotc_byte_t a, input aotc_byte_t e);
    @(posedge clk) #1;
    reg_addr = a;
    #1;
    chk_reg(reg_rdata, e);
  endtask
  // Edges from a sample step until it shows; bounded so a stuck path cannot hang
  task automatic lat(output int n);
    @(posedge clk) #1;
    adc_sample = ~adc_sample;
    n = 0;
    while (out_data !== adc_sample && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================
  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    resetn = 1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 7; i++) rd(adr[i], rst[i]);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(adr[i], 8'hff);
      rd(adr[i], msk[i]);
    end
    chk_word({chop_enable, lvds_reduced, drive_double, drive_termination, vref_select,
              offset_trim_value}, 16'hffff);
    wr(`AOTC_ADDR_TEST, 8'h00);
    wr(`AOTC_ADDR_OFMT, 8'h00);
    wr(`AOTC_ADDR_OPHS, 8'h00);
    chk_word(out_data, 12'h5a3);
    for (int i = 0; i < 6; i++) begin
      wr(`AOTC_ADDR_TEST, {4'h0, fmode[i]});
      chk_word(out_data, fpat[i]);
    end
    // Toggling patterns: each word must be the complement of the one before
    for (int i = 0; i < 3; i++) begin
      wr(`AOTC_ADDR_TEST, {4'h0, amode[i]});
      chk_word(out_data ^ prev, 12'hfff);
    end
    wr(`AOTC_ADDR_TEST, 8'h08);
    chk_word(out_data, 12'h123);
    wr(`AOTC_ADDR_TEST, 8'h48);
    chk_word(out_data ^ prev, 12'hece);
    // Leave user mode first so each single-shot run starts again from pattern one
    wr(`AOTC_ADDR_TEST, 8'h00);
    wr(`AOTC_ADDR_TEST, 8'h88);
    chk_word(prev, 12'h123);
    chk_word(out_data, 12'h000);
    repeat (3) @(posedge clk);
    #1;
    chk_word(out_data, 12'h000);
    wr(`AOTC_ADDR_TEST, 8'h00);
    wr(`AOTC_ADDR_TEST, 8'hc8);
    chk_word(prev, 12'h123);
    chk_word(out_data, 12'hfed);
    repeat (3) @(posedge clk);
    #1;
    chk_word(out_data, 12'h000);
    // The hold bit acts one edge after the write, so the first word after it is still running
    wr(`AOTC_ADDR_TEST, 8'h25);
    @(posedge clk) #1;
    chk_word({out_data, 4'h0} & {prev, 4'h0}, 16'hfff0);
    wr(`AOTC_ADDR_TEST, 8'h05);
    repeat (30) @(posedge clk);
    #1;
    chk_word({15'h0, out_data === 12'hfff}, 16'h0000);
    wr(`AOTC_ADDR_TEST, 8'h16);
    @(posedge clk) #1;
    chk_word({out_data, 4'h0} & {prev, 4'h0}, 16'hfff0);
    wr(`AOTC_ADDR_TEST, 8'h00);
    wr(`AOTC_ADDR_OFMT, 8'h01);
    chk_word(out_data, 12'hda3);
    wr(`AOTC_ADDR_OFMT, 8'h04);
    chk_word(out_data, 12'ha5c);
    wr(`AOTC_ADDR_OFMT, 8'h00);
    for (int k = 0; k < 12; k++) begin
      wr(`AOTC_ADDR_OPHS, k[7:0]);
      chk_word({15'h0, out_clock}, {15'h0, div_ph[k]});
    end
    wr(`AOTC_ADDR_OPHS, 8'h0f);
    chk_word({15'h0, out_clock}, {15'h0, div_ph[11]});
    wr(`AOTC_ADDR_OPHS, 8'h00);
    lat(n0);
    wr(`AOTC_ADDR_OPHS, 8'h30);
    repeat (6) @(posedge clk);
    lat(n1);
    chk_word(16'(n0), 16'h0001);
    chk_word(16'(n1), 16'(n0 + 3));
    // Enable low: a write and a new sample must both be ignored
    @(posedge clk) #1;
    ce = 0;
    adc_sample = ~adc_sample;
    wr(`AOTC_ADDR_TEST, 8'h02);
    chk_word(out_data, 12'h5a3);
    ce = 1;
    rd(`AOTC_ADDR_TEST, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
